// >>> hw/dual_freq_cal_switch_ctrl.sv
// calibration sequencing and two-set switching with loop-filter switch drive
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "dual_freq_cal_switch_cfg.svh"

module dual_freq_cal_switch_ctrl #(
  parameter int CAL_W = `CAL_W
) (
  input  wire logic                                sys_clk,
  input  wire logic                                rstn,
  // apb slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [11:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // set toggle pin from host
  input  wire logic                                toggle_pin,
  // calibration engine handshake
  output dual_freq_cal_switch_pkg::cal_req_t       cal_req,
  input  wire dual_freq_cal_switch_pkg::cal_rsp_t  cal_rsp,
  // loop-filter switches and output ports
  output logic                                     loop_switch_out_a,
  output logic                                     loop_switch_out_b,
  output dual_freq_cal_switch_pkg::port_cfg_t      rf_transmit_port,
  output dual_freq_cal_switch_pkg::port_cfg_t      rf_receive_port,
  output logic                                     active_set
);

  // ==========================================================================
  // reset release
  logic rst_meta_q;
  logic rst_n_q;

  // asynchronous assert, two-flop release so no flop leaves reset on a skewed edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ==========================================================================
  // register file
  logic [31:0] main_ctrl_q, main_ctrl_d;
  logic [31:0] buf_cfg_q, buf_cfg_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic        mc_wr;
  logic        access;

  logic        vco_cal_enable;
  logic        dual_cal_at_init;
  logic        forced_reinit_cal;
  logic        active_set_select;
  logic        pin_set_switch_enable;

  logic [CAL_W-1:0] seed_a;
  logic [CAL_W-1:0] seed_b;
  logic             valid_a_q, valid_b_q, valid_a_d, valid_b_d;
  logic             locked_q, locked_d;
  dual_freq_cal_switch_pkg::cal_state_t state_q, state_d;

  assign vco_cal_enable        = main_ctrl_q[`MC_CAL_EN_BIT];
  assign dual_cal_at_init      = main_ctrl_q[`MC_DUAL_INIT_BIT];
  assign forced_reinit_cal     = main_ctrl_q[`MC_REINIT_BIT];
  assign active_set_select     = main_ctrl_q[`MC_SET_SEL_BIT];
  assign pin_set_switch_enable = main_ctrl_q[`MC_PIN_SW_BIT];

  // one wait state: access taken on the first penable cycle, pready the next
  assign access = psel && penable && !pready_q;
  assign mc_wr  = access && pwrite && (paddr == `MAIN_CTRL_OFS);

  // apb decode and register update
  always_comb begin
    main_ctrl_d = main_ctrl_q;
    buf_cfg_d   = buf_cfg_q;
    prdata_d    = prdata_q;
    pready_d    = 1'b0;
    pslverr_d   = 1'b0;
    if (access) begin
      pready_d = 1'b1;
      prdata_d = 32'h0000_0000;
      if (paddr == `MAIN_CTRL_OFS) begin
        if (pwrite) begin
          main_ctrl_d = {27'h0, pwdata[4:0]};
        end
        prdata_d = main_ctrl_q;
      end else if (paddr == `BUF_CFG_OFS) begin
        if (pwrite) begin
          buf_cfg_d = pwdata;
        end
        prdata_d = buf_cfg_q;
      end else if (paddr == `STATUS_OFS) begin
        prdata_d = {27'h0, locked_q, valid_b_q, valid_a_q,
                    (state_q != dual_freq_cal_switch_pkg::ST_IDLE), active_set};
      end else if (paddr == `SEED_A_OFS) begin
        prdata_d = {{(32-CAL_W){1'b0}}, seed_a};
      end else if (paddr == `SEED_B_OFS) begin
        prdata_d = {{(32-CAL_W){1'b0}}, seed_b};
      end else begin
        pslverr_d = 1'b1; // unmapped: error, reads zero
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      main_ctrl_q <= `MC_RESET_VAL;
      buf_cfg_q   <= `BC_RESET_VAL;
      prdata_q    <= 32'h0000_0000;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
    end else begin
      main_ctrl_q <= main_ctrl_d;
      buf_cfg_q   <= buf_cfg_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // active set selection
  logic active_q, active_d;
  logic pin_q, pin_d;
  logic init_q, init_d;      // first main control write after reset counts as init
  logic switched;
  logic mc_wr_q;             // write seen, its new bits are visible next cycle
  logic sel_old_q, sel_old_d;

  // pin changes swap the set only when pin switching is enabled, select changes load it; the pin swaps relative to now and wins a tie
  always_comb begin
    active_d  = active_q;
    pin_d     = toggle_pin;
    sel_old_d = active_set_select;
    switched  = 1'b0;
    if (pin_set_switch_enable && (toggle_pin != pin_q)) begin
      active_d = ~active_q;
      switched = 1'b1;
    end else if (active_set_select != sel_old_q) begin
      active_d = active_set_select;
      switched = (active_set_select != active_q);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      active_q  <= 1'b0;
      pin_q     <= 1'b0;
      sel_old_q <= 1'b0;
    end else begin
      active_q  <= active_d;
      pin_q     <= pin_d;
      sel_old_q <= sel_old_d;
    end
  end

  assign active_set = active_q;

  // ==========================================================================
  // calibration sequencer
  logic             pend_q, pend_d;     // a switch waits while busy
  logic             both_q, both_d;     // pending job covers both sets
  logic             run_both_q, run_both_d; // running job covers both sets, safe from a queued job
  logic             first_q, first_d;   // set index of first job
  logic             idx_q, idx_d;
  logic             req_v_q, req_v_d;
  logic [CAL_W-1:0] rd_data;
  logic             store_wr;

  // decide the job kind, then walk request and done for one or two sets
  always_comb begin
    state_d   = state_q;
    pend_d    = pend_q;
    both_d    = both_q;
    run_both_d = run_both_q;
    first_d   = first_q;
    idx_d     = idx_q;
    req_v_d   = 1'b0;
    valid_a_d = valid_a_q;
    valid_b_d = valid_b_q;
    locked_d  = locked_q;
    init_d    = init_q;
    store_wr  = 1'b0;
    // a main control write starts a job when cal enable is set; the first write after reset, enabled or not, is init
    if (mc_wr_q && vco_cal_enable) begin
      pend_d  = 1'b1;
      both_d  = forced_reinit_cal
              || (!init_q && dual_cal_at_init);
      first_d = active_d;                                    // a select write calibrates the new set
      init_d  = 1'b1;
    end else if (mc_wr_q) begin
      init_d  = 1'b1;
    end else if (switched && vco_cal_enable) begin
      pend_d  = 1'b1;
      both_d  = forced_reinit_cal;
      first_d = active_d;
    end
    if (switched || mc_wr_q) begin
      locked_d = 1'b0;
    end
    case (state_q)
      dual_freq_cal_switch_pkg::ST_IDLE: begin
        if (pend_q) begin
          pend_d     = (mc_wr_q || switched) && vco_cal_enable; // a job landing now stays queued
          idx_d      = first_q;
          run_both_d = both_q;
          state_d = dual_freq_cal_switch_pkg::ST_REQ_A;
        end else if (!switched && !mc_wr_q) begin
          locked_d = 1'b1;
        end
      end
      dual_freq_cal_switch_pkg::ST_REQ_A: begin
        req_v_d = 1'b1;                                      // seed read is one cycle late
        state_d = dual_freq_cal_switch_pkg::ST_WAIT_A;
      end
      dual_freq_cal_switch_pkg::ST_WAIT_A: begin
        req_v_d = 1'b1;
        if (cal_rsp.done && req_v_q) begin
          req_v_d  = 1'b0;
          store_wr = 1'b1;
          if (idx_q) valid_b_d = 1'b1;
          else       valid_a_d = 1'b1;
          if (run_both_q) begin
            idx_d   = ~idx_q;
            state_d = dual_freq_cal_switch_pkg::ST_REQ_B;
          end else begin
            state_d = dual_freq_cal_switch_pkg::ST_IDLE;
          end
        end
      end
      dual_freq_cal_switch_pkg::ST_REQ_B: begin
        state_d = dual_freq_cal_switch_pkg::ST_WAIT_B;
      end
      dual_freq_cal_switch_pkg::ST_WAIT_B: begin
        req_v_d = 1'b1;
        if (cal_rsp.done && req_v_q) begin
          req_v_d  = 1'b0;
          store_wr = 1'b1;
          if (idx_q) valid_b_d = 1'b1;
          else       valid_a_d = 1'b1;
          state_d  = dual_freq_cal_switch_pkg::ST_IDLE;
        end
      end
      default: state_d = dual_freq_cal_switch_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q   <= dual_freq_cal_switch_pkg::ST_IDLE;
      pend_q    <= 1'b0;
      both_q    <= 1'b0;
      run_both_q <= 1'b0;
      first_q   <= 1'b0;
      idx_q     <= 1'b0;
      req_v_q   <= 1'b0;
      valid_a_q <= 1'b0;
      valid_b_q <= 1'b0;
      locked_q  <= 1'b0;
      init_q    <= 1'b0;
      mc_wr_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      pend_q    <= pend_d;
      both_q    <= both_d;
      run_both_q <= run_both_d;
      first_q   <= first_d;
      idx_q     <= idx_d;
      req_v_q   <= req_v_d;
      valid_a_q <= valid_a_d;
      valid_b_q <= valid_b_d;
      locked_q  <= locked_d;
      init_q    <= init_d;
      mc_wr_q   <= mc_wr;
    end
  end

  // seed for the target set comes from its last stored result
  cal_store #(
    .W       (CAL_W)
  ) u_store (
    .clk     (sys_clk),
    .rst_n   (rst_n_q),
    .wr_en   (store_wr),
    .wr_idx  (idx_q),
    .wr_data (cal_rsp.result),
    .rd_idx  (idx_q),
    .rd_data (rd_data),
    .data_a  (seed_a),
    .data_b  (seed_b)
  );

  assign cal_req = '{valid:   req_v_q,
                     set_idx: idx_q,
                     seed:    rd_data};

  // ==========================================================================
  // loop-filter switches and port settings
  logic                                sw_a_q, sw_b_q;
  dual_freq_cal_switch_pkg::port_cfg_t tx_q, tx_d, rx_q, rx_d;

  // power field picked by the active set so each set keeps its own level
  always_comb begin
    tx_d.open_drain = buf_cfg_q[`BC_TX_STYLE_BIT];
    rx_d.open_drain = buf_cfg_q[`BC_RX_STYLE_BIT];
    tx_d.power = active_q ? buf_cfg_q[`BC_TX_PWR_B_LSB +: `BC_PWR_W]
                          : buf_cfg_q[`BC_TX_PWR_A_LSB +: `BC_PWR_W];
    rx_d.power = active_q ? buf_cfg_q[`BC_RX_PWR_B_LSB +: `BC_PWR_W]
                          : buf_cfg_q[`BC_RX_PWR_A_LSB +: `BC_PWR_W];
  end

  // exactly one switch closed once out of reset (reset opens both), each holding its own filter charge
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sw_a_q <= 1'b0;
      sw_b_q <= 1'b0;
      tx_q   <= '0;
      rx_q   <= '0;
    end else begin
      sw_a_q <= ~active_q;
      sw_b_q <= active_q;
      tx_q   <= tx_d;
      rx_q   <= rx_d;
    end
  end

  assign loop_switch_out_a = sw_a_q;
  assign loop_switch_out_b = sw_b_q;
  assign rf_transmit_port  = tx_q;
  assign rf_receive_port   = rx_q;

endmodule : dual_freq_cal_switch_ctrl

// >>> hw/dual_freq_cal_switch_cfg.svh
// register offsets, field positions, reset values and widths for the set switch controller
`ifndef DUAL_FREQ_CAL_SWITCH_CFG_SVH
`define DUAL_FREQ_CAL_SWITCH_CFG_SVH

// ==========================================================================
// register byte offsets
`define MAIN_CTRL_OFS      12'h000
`define BUF_CFG_OFS        12'h004
`define STATUS_OFS         12'h008
`define SEED_A_OFS         12'h00C
`define SEED_B_OFS         12'h010

// ==========================================================================
// main control register fields
`define MC_CAL_EN_BIT      0
`define MC_DUAL_INIT_BIT   1
`define MC_REINIT_BIT      2
`define MC_SET_SEL_BIT     3
`define MC_PIN_SW_BIT      4
`define MC_RESET_VAL       32'h0000_0000

// ==========================================================================
// buffer config register fields
`define BC_TX_STYLE_BIT    0
`define BC_RX_STYLE_BIT    1
`define BC_TX_PWR_A_LSB    8
`define BC_RX_PWR_A_LSB    14
`define BC_TX_PWR_B_LSB    20
`define BC_RX_PWR_B_LSB    26
`define BC_PWR_W           6
`define BC_RESET_VAL       32'h0000_0000

// ==========================================================================
// status register fields
`define ST_ACTIVE_BIT      0
`define ST_BUSY_BIT        1
`define ST_VALID_A_BIT     2
`define ST_VALID_B_BIT     3
`define ST_LOCKED_BIT      4

// ==========================================================================
// calibration data width
`define CAL_W              8

`endif

// >>> hw/dual_freq_cal_switch_pkg.sv
// types for the set switch controller
package dual_freq_cal_switch_pkg;

  // calibration sequencer states
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_REQ_A  = 5'b00010,
    ST_WAIT_A = 5'b00100,
    ST_REQ_B  = 5'b01000,
    ST_WAIT_B = 5'b10000
  } cal_state_t;

  // request carried to the calibration engine
  typedef struct packed {
    logic       valid;
    logic       set_idx;
    logic [7:0] seed;
  } cal_req_t;

  // answer from the calibration engine
  typedef struct packed {
    logic       done;
    logic [7:0] result;
  } cal_rsp_t;

  // per-port output settings
  typedef struct packed {
    logic       open_drain;
    logic [5:0] power;
  } port_cfg_t;

endpackage : dual_freq_cal_switch_pkg

// >>> hw/cal_store.sv
// two-entry calibration data store with registered read
`timescale 1ns/1ps
`include "dual_freq_cal_switch_cfg.svh"

module cal_store #(
  parameter int W = `CAL_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         wr_en,
  input  wire logic         wr_idx,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_idx,
  output logic      [W-1:0] rd_data,
  output logic      [W-1:0] data_a,
  output logic      [W-1:0] data_b
);

  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic [W-1:0] rd_q;
  logic [W-1:0] rd_d;

  // write one entry, read the other path through a register
  always_comb begin
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    if (wr_en) begin
      mem_d[wr_idx] = wr_data;
    end
    rd_d = mem_d[rd_idx];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      rd_q     <= '0;
    end else begin
      mem_q[0] <= mem_d[0];
      mem_q[1] <= mem_d[1];
      rd_q     <= rd_d;
    end
  end

  assign rd_data = rd_q;
  assign data_a  = mem_q[0];
  assign data_b  = mem_q[1];

endmodule : cal_store

// >>> bench/cal_engine_model.sv
// calibration engine stand-in on the far side of the request/done handshake
`timescale 1ns/1ps

module cal_engine_model #(
  parameter logic [7:0] STEP = 8'h11
) (
  input  wire logic                               sys_clk,
  input  wire logic                               rstn,
  input  wire logic [3:0]                         lat,
  input  wire dual_freq_cal_switch_pkg::cal_req_t cal_req,
  output dual_freq_cal_switch_pkg::cal_rsp_t      cal_rsp
);
  logic [3:0] wait_q;

  // ======
  // answer after lat held cycles; result drifts from the seed so stale data shows
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q  <= 4'h0;
      cal_rsp <= '0;
    end else if (cal_req.valid && !cal_rsp.done && wait_q >= lat) begin
      wait_q  <= 4'h0;
      cal_rsp <= {1'b1, cal_req.seed + STEP};
    end else begin
      wait_q  <= cal_req.valid ? wait_q + 4'h1 : 4'h0;
      cal_rsp <= {1'b0, ~cal_rsp.result}; // result churns outside done
    end
  end
endmodule : cal_engine_model

// >>> bench/dual_freq_cal_switch_chk.sv
// port-level assertions for the set switch controller
`timescale 1ns/1ps
`include "dual_freq_cal_switch_cfg.svh"

module dual_freq_cal_switch_chk #(
  parameter int CAL_W = `CAL_W
) (
  input wire logic                                sys_clk,
  input wire logic                                rstn,
  input wire logic                                psel,
  input wire logic                                penable,
  input wire logic                                pwrite,
  input wire logic [11:0]                         paddr,
  input wire logic [31:0]                         pwdata,
  input wire logic [31:0]                         prdata,
  input wire logic                                pready,
  input wire logic                                pslverr,
  input wire logic                                toggle_pin,
  input wire dual_freq_cal_switch_pkg::cal_req_t  cal_req,
  input wire dual_freq_cal_switch_pkg::cal_rsp_t  cal_rsp,
  input wire logic                                loop_switch_out_a,
  input wire logic                                loop_switch_out_b,
  input wire dual_freq_cal_switch_pkg::port_cfg_t rf_transmit_port,
  input wire dual_freq_cal_switch_pkg::port_cfg_t rf_receive_port,
  input wire logic                                active_set
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic       wr_take;
  logic       tog_q;
  logic [2:0] up_q;
  logic [2:0] age_q;
  logic       en_q;
  logic [1:0] seen_q;
  logic [7:0] last_q [2];

  // ======
  // helper state: settle count, age of last cause, enable copy, last results
  assign wr_take = psel && penable && pwrite && !pready;
  always_ff @(posedge sys_clk) tog_q <= toggle_pin;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      up_q   <= '0;
      age_q  <= '1;
      en_q   <= 1'b0;
      seen_q <= '0;
      last_q <= '{default: '0};
    end else begin
      up_q  <= (up_q == 3'h7) ? up_q : up_q + 3'h1;
      age_q <= (wr_take || toggle_pin != tog_q) ? 3'h0 : (age_q == 3'h7) ? age_q : age_q + 3'h1;
      if (wr_take && paddr == `MAIN_CTRL_OFS) en_q <= pwdata[`MC_CAL_EN_BIT];
      if (cal_req.valid && cal_rsp.done) begin
        seen_q[cal_req.set_idx] <= 1'b1;
        last_q[cal_req.set_idx] <= cal_rsp.result;
      end
    end
  end

  // ======
  // assertions
  a_switch_a_tracks: assert property (up_q == 3'h7 |-> loop_switch_out_a == !$past(active_set))
    else $error("switch a off its set");
  a_switch_b_tracks: assert property (up_q == 3'h7 |-> loop_switch_out_b == $past(active_set))
    else $error("switch b off its set");
  a_set_has_cause: assert property (up_q == 3'h7 && $changed(active_set) |-> age_q <= 3'h4)
    else $error("set changed without cause");
  a_port_has_cause: assert property (up_q == 3'h7 && $changed(rf_transmit_port) |-> age_q <= 3'h5)
    else $error("port setting changed without cause");
  a_req_held: assert property (cal_req.valid && !cal_rsp.done |=> cal_req.valid && $stable(cal_req))
    else $error("request dropped early");
  a_req_drops: assert property (cal_req.valid && cal_rsp.done |=> !cal_req.valid)
    else $error("request held after done");
  a_write_cals: assert property (wr_take && paddr == `MAIN_CTRL_OFS && pwdata[0] |-> ##[1:60] cal_req.valid)
    else $error("control write made no job");
  a_cal_gated: assert property ($rose(cal_req.valid) |-> en_q)
    else $error("job while disabled");
  a_seed_last: assert property ($rose(cal_req.valid) && seen_q[cal_req.set_idx] |->
    cal_req.seed == last_q[cal_req.set_idx]) else $error("seed is not last result");
endmodule : dual_freq_cal_switch_chk

bind dual_freq_cal_switch_ctrl dual_freq_cal_switch_chk #(.CAL_W(CAL_W)) chk_i (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .toggle_pin(toggle_pin),
  .cal_req(cal_req), .cal_rsp(cal_rsp), .loop_switch_out_a(loop_switch_out_a),
  .loop_switch_out_b(loop_switch_out_b), .rf_transmit_port(rf_transmit_port),
  .rf_receive_port(rf_receive_port), .active_set(active_set)
);

// >>> bench/dual_freq_cal_switch_ctrl_tb_top.sv
// self-checking bench for the set switch controller
`timescale 1ns/1ps
`include "dual_freq_cal_switch_cfg.svh"
`define CHK(x, y) begin checks++; if ((x) !== (y)) begin errors++; $display("CHECK FAILED %0t got %h want %h", $time, x, y); end end

module dual_freq_cal_switch_ctrl_tb_top;
  localparam logic [7:0]  STEP = 8'h11;
  localparam logic [31:0] BUF_W = (32'h15 << `BC_TX_PWR_A_LSB) | (32'h2A << `BC_RX_PWR_A_LSB)
                                | (32'h0C << `BC_TX_PWR_B_LSB) | (32'h33 << `BC_RX_PWR_B_LSB) | 32'h1;
  logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr, toggle_pin, se;
  logic        loop_switch_out_a, loop_switch_out_b, active_set;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  ea, eb;
  logic [3:0]  lat;
  int          errors, checks, cycles;
  dual_freq_cal_switch_pkg::cal_req_t  cal_req;
  dual_freq_cal_switch_pkg::cal_rsp_t  cal_rsp;
  dual_freq_cal_switch_pkg::port_cfg_t rf_transmit_port, rf_receive_port;

  dual_freq_cal_switch_ctrl DUT (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .toggle_pin(toggle_pin),
    .cal_req(cal_req), .cal_rsp(cal_rsp), .loop_switch_out_a(loop_switch_out_a),
    .loop_switch_out_b(loop_switch_out_b), .rf_transmit_port(rf_transmit_port),
    .rf_receive_port(rf_receive_port), .active_set(active_set)
  );
  cal_engine_model #(.STEP(STEP)) partner (
    .sys_clk(sys_clk), .rstn(rstn), .lat(lat), .cal_req(cal_req), .cal_rsp(cal_rsp)
  );

  // ======
  // clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  // ======
  // bus and pin helpers; one idle edge after each transfer avoids double drives
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic idle;
    int q;
    q = 0;
    while (q < 8) begin
      @(posedge sys_clk);
      q = (cal_req.valid === 1'b1) ? 0 : q + 1;
    end
  endtask : idle
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle();
  endtask : wr
  task automatic flip;
    toggle_pin <= ~toggle_pin;
    idle();
  endtask : flip
  task automatic chk_set(input logic s);
    `CHK(active_set, s)
    `CHK(loop_switch_out_a, ~s)
    `CHK(loop_switch_out_b, s)
  endtask : chk_set
  task automatic chk_data;
    apb(1'b0, `SEED_A_OFS, 32'h0);
    `CHK(r, {24'h0, ea})
    apb(1'b0, `SEED_B_OFS, 32'h0);
    `CHK(r, {24'h0, eb})
  endtask : chk_data
  task automatic chk_valid(input logic va, input logic vb);
    apb(1'b0, `STATUS_OFS, 32'h0);
    `CHK(r[`ST_VALID_A_BIT], va)
    `CHK(r[`ST_VALID_B_BIT], vb)
  endtask : chk_valid
  task automatic do_reset;
    rstn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk_set(1'b0);
  endtask : do_reset

  // ======
  // scenarios
  task automatic t_init_single;
    wr(`MAIN_CTRL_OFS, 32'h1);
    chk_valid(1'b1, 1'b0);
    ea = STEP;
    eb = 8'h00;
    chk_data();
  endtask : t_init_single
  task automatic t_init_dual;
    lat <= 4'h5;
    wr(`MAIN_CTRL_OFS, 32'h3);
    chk_valid(1'b1, 1'b1);
    ea = STEP;
    eb = STEP;
    chk_data();
  endtask : t_init_dual
  task automatic t_pin;
    lat <= 4'h0;
    wr(`MAIN_CTRL_OFS, 32'h13);
    ea += STEP;
    flip();
    chk_set(1'b1);
    eb += STEP;
    flip();
    chk_set(1'b0);
    ea += STEP;
    chk_data();
  endtask : t_pin
  task automatic t_off;
    wr(`MAIN_CTRL_OFS, 32'h1A);
    chk_set(1'b1);
    flip();
    chk_set(1'b0);
    flip();
    chk_data();
  endtask : t_off
  task automatic t_reinit;
    wr(`MAIN_CTRL_OFS, 32'h1F);
    ea += STEP;
    eb += STEP;
    chk_valid(1'b1, 1'b1);
    `CHK(r[`ST_LOCKED_BIT], 1'b1)
    chk_data();
    flip();
    ea += STEP;
    eb += STEP;
    chk_data();
    wr(`MAIN_CTRL_OFS, 32'h1B);
    ea += STEP;
    chk_set(1'b0);
    chk_data();
  endtask : t_reinit
  task automatic t_buf;
    wr(`BUF_CFG_OFS, BUF_W);
    `CHK(rf_transmit_port, {1'b1, 6'h15})
    `CHK(rf_receive_port, {1'b0, 6'h2A})
    apb(1'b0, `BUF_CFG_OFS, 32'h0);
    `CHK(r, BUF_W)
    flip();
    eb += STEP;
    `CHK(rf_transmit_port, {1'b1, 6'h0C})
    `CHK(rf_receive_port, {1'b0, 6'h33})
    apb(1'b0, 12'h020, 32'h0);
    `CHK(se, 1'b1)
    `CHK(r, 32'h0)
    wr(`MAIN_CTRL_OFS, 32'h13);
    ea += STEP;
    chk_set(1'b0);
    chk_data();
  endtask : t_buf

  // ======
  // verdict
  task automatic wrap_up;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    {rstn, psel, penable, pwrite, toggle_pin} = '0;
    paddr = '0;
    pwdata = '0;
    lat = '0;
    errors = 0;
    checks = 0;
    cycles = 0;
    @(posedge sys_clk);
    do_reset();
    t_init_single();
    do_reset();
    t_init_dual();
    t_pin();
    t_off();
    t_reinit();
    t_buf();
    wrap_up();
  end
endmodule : dual_freq_cal_switch_ctrl_tb_top
